// ---- hw/mrc_top.sv ----
// mrc_top: prioritised region checker with APB register file and interrupt
// assumes fetch and load/store stages hold no state here; result follows one cycle later
`timescale 1ns/10ps
module mrc_top #(
   parameter int NREG = mrc_pkg::MRC_REGIONS_DEF
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [2:0]        pprot,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // access check
   input  wire mrc_pkg::mrc_req_s chk_req,
   output mrc_pkg::mrc_rsp_s      chk_rsp,
   // interrupt
   output logic                   irq
);
   import mrc_pkg::*;

   // region match with subregion check; sizes below 256 bytes never match
   function automatic logic region_hit(input logic [31:0] addr, input mrc_region_s r);
      logic [5:0]  sz;
      logic [32:0] span;
      logic [31:0] mask;
      logic [31:0] sub;
      sz   = {1'b0, r.size} + 6'h01;
      span = 33'h000000001 << sz;
      mask = ~(span[31:0] - 32'h00000001);
      sub  = addr >> (sz - 6'h03);
      region_hit = r.en && (r.size >= MRC_SIZE_MIN)
                   && ((addr & mask) == (r.base & mask))
                   && !r.srd[sub[2:0]];
   endfunction

   // read and write grant for the current mode; {read, write}
   function automatic logic [1:0] ap_grant(input logic [2:0] ap, input logic priv);
      case (ap)
         3'h1:    ap_grant = priv ? 2'h3 : 2'h0;
         3'h2:    ap_grant = priv ? 2'h3 : 2'h2;
         3'h3:    ap_grant = 2'h3;
         3'h5:    ap_grant = priv ? 2'h2 : 2'h0;
         3'h6:    ap_grant = 2'h2;
         // reserved codes 4 and 7 give no access
         default: ap_grant = 2'h0;
      endcase
   endfunction

   // register state
   mrc_region_s rgn      [NREG];
   mrc_region_s next_rgn [NREG];
   logic        mpu_en, next_mpu_en;
   logic        background_region_enable, next_background_region_enable;
   logic [3:0]  rgn_sel, next_rgn_sel;
   logic [31:0] tcm_base, next_tcm_base;
   logic [4:0]  tcm_size, next_tcm_size;
   logic [1:0]  int_stat, next_int_stat;
   logic [1:0]  int_mask, next_int_mask;
   logic [31:0] flt_addr, next_flt_addr;
   logic [31:0] next_prdata;
   logic        next_pslverr;
   mrc_rsp_s    next_rsp;

   logic        setup, wr_acc, priv_ok, sel_ok;
   mrc_region_s cur;
   mrc_region_s tcm_r;

   logic [NREG-1:0] rgn_hit;
   logic            any_hit;
   logic [3:0]      win_idx;
   logic            tcm_hit;

   // no wait states: every answer is prepared in the setup cycle
   assign pready  = 1'b1;
   assign setup   = psel && !penable;
   assign priv_ok = pprot[0];
   // out-of-range select: writes dropped, reads fall back to region 0
   assign sel_ok  = {1'b0, rgn_sel} < 5'(NREG);
   assign wr_acc  = psel && penable && pwrite && priv_ok;
   assign cur     = rgn[sel_ok ? rgn_sel : 4'h0];
   // level output: stays high until software clears the status bit or its mask bit
   assign irq     = |(int_stat & int_mask);

   // tcm window reuses the region matcher with every subregion on
   always_comb begin
      tcm_r      = '0;
      tcm_r.base = tcm_base;
      tcm_r.size = tcm_size;
      tcm_r.en   = 1'b1;
   end

   // one matcher per region, all in parallel; the pick below stays a short chain
   generate
      for (genvar g = 0; g < NREG; g++) begin : g_match
         assign rgn_hit[g] = region_hit(chk_req.addr, rgn[g]);
      end
   endgenerate

   // priority pick: a higher-index hit overrides every lower one
   always_comb begin
      any_hit = 1'b0;
      win_idx = 4'h0;
      for (int i = 0; i < NREG; i++) begin
         if (rgn_hit[i]) begin
            any_hit = 1'b1;
            win_idx = 4'(i);
         end
      end
   end

   assign tcm_hit = mpu_en && region_hit(chk_req.addr, tcm_r);

   // access check
   always_comb begin
      logic [1:0] gr;
      gr             = 2'h0;
      next_rsp       = '0;
      next_rsp.valid = chk_req.valid;
      next_rsp.kind  = MRC_FK_NONE;
      if (!mpu_en) begin
         next_rsp.rd_ok    = 1'b1;
         next_rsp.wr_ok    = 1'b1;
         next_rsp.attr.tex = MRC_TEX_NORMAL;
      end else if (any_hit) begin
         gr              = ap_grant(rgn[win_idx].ap, chk_req.priv);
         next_rsp.hit    = 1'b1;
         next_rsp.region = win_idx;
         next_rsp.rd_ok  = gr[1];
         next_rsp.wr_ok  = gr[0];
         next_rsp.attr   = rgn[win_idx].attr;
         if (chk_req.fetch ? (rgn[win_idx].execute_never_flag || !gr[1])
                           : (chk_req.write ? !gr[0] : !gr[1]))
            next_rsp.kind = MRC_FK_PERM;
      end else if (background_region_enable && chk_req.priv) begin
         // default map: privileged misses pass with normal attributes
         next_rsp.rd_ok    = 1'b1;
         next_rsp.wr_ok    = 1'b1;
         next_rsp.attr.tex = MRC_TEX_NORMAL;
      end else begin
         next_rsp.kind = MRC_FK_BACKGROUND;
      end
      if (tcm_hit)
         next_rsp.attr = '{tex: MRC_TEX_NORMAL, c: 1'b0, b: 1'b0, s: 1'b0};
      next_rsp.fault = chk_req.valid && (next_rsp.kind != MRC_FK_NONE);
   end

   // register writes, sticky status and read mux
   always_comb begin
      next_rgn                      = rgn;
      next_mpu_en                   = mpu_en;
      next_background_region_enable = background_region_enable;
      next_rgn_sel                  = rgn_sel;
      next_tcm_base                 = tcm_base;
      next_tcm_size                 = tcm_size;
      next_int_mask                 = int_mask;
      next_int_stat                 = int_stat;
      next_flt_addr                 = flt_addr;
      next_prdata                   = 32'h00000000;
      next_pslverr                  = 1'b0;
      if (wr_acc) begin
         case (paddr)
            MRC_OFS_CTRL: begin
               next_mpu_en                   = pwdata[MRC_CTRL_EN_BIT];
               next_background_region_enable = pwdata[MRC_CTRL_BGEN_BIT];
            end
            MRC_OFS_RGN_SEL: next_rgn_sel = pwdata[3:0];
            MRC_OFS_RGN_BASE: begin
               if (sel_ok)
                  next_rgn[rgn_sel].base = pwdata & MRC_BASE_MASK;
            end
            MRC_OFS_RGN_SIZE: begin
               if (sel_ok) begin
                  next_rgn[rgn_sel].en   = pwdata[MRC_SIZE_EN_BIT];
                  next_rgn[rgn_sel].size = pwdata[MRC_SIZE_LSB +: 5];
                  next_rgn[rgn_sel].srd  = pwdata[MRC_SRD_LSB +: 8];
               end
            end
            MRC_OFS_RGN_ACC: begin
               if (sel_ok) begin
                  next_rgn[rgn_sel].attr.b   = pwdata[MRC_ACC_B_BIT];
                  next_rgn[rgn_sel].attr.c   = pwdata[MRC_ACC_C_BIT];
                  next_rgn[rgn_sel].attr.s   = pwdata[MRC_ACC_S_BIT];
                  next_rgn[rgn_sel].attr.tex = pwdata[MRC_ACC_TEX_LSB +: 3];
                  next_rgn[rgn_sel].ap       = pwdata[MRC_ACC_AP_LSB +: 3];
                  next_rgn[rgn_sel].execute_never_flag = pwdata[MRC_ACC_NOEXEC_BIT];
               end
            end
            MRC_OFS_TCM_BASE: next_tcm_base = pwdata & MRC_BASE_MASK;
            MRC_OFS_TCM_SIZE: next_tcm_size = pwdata[4:0];
            MRC_OFS_INT_STAT: next_int_stat = int_stat & ~pwdata[1:0];
            MRC_OFS_INT_MASK: next_int_mask = pwdata[1:0];
            default: ;
         endcase
      end
      // hardware set wins over a same-cycle clear
      if (next_rsp.fault) begin
         next_flt_addr = chk_req.addr;
         if (next_rsp.kind == MRC_FK_PERM)
            next_int_stat[MRC_INT_PERM_BIT] = 1'b1;
         else
            next_int_stat[MRC_INT_BG_BIT] = 1'b1;
      end
      // answer prepared in setup so it stands in the access phase
      if (setup) begin
         if (!priv_ok) begin
            next_pslverr = 1'b1;
         end else begin
            case (paddr)
               MRC_OFS_CTRL: begin
                  next_prdata[MRC_CTRL_EN_BIT]   = mpu_en;
                  next_prdata[MRC_CTRL_BGEN_BIT] = background_region_enable;
               end
               MRC_OFS_RGN_SEL:  next_prdata[3:0] = rgn_sel;
               MRC_OFS_RGN_BASE: next_prdata = cur.base;
               MRC_OFS_RGN_SIZE: begin
                  next_prdata[MRC_SIZE_EN_BIT]      = cur.en;
                  next_prdata[MRC_SIZE_LSB +: 5]    = cur.size;
                  next_prdata[MRC_SRD_LSB +: 8]     = cur.srd;
               end
               MRC_OFS_RGN_ACC: begin
                  next_prdata[MRC_ACC_B_BIT]        = cur.attr.b;
                  next_prdata[MRC_ACC_C_BIT]        = cur.attr.c;
                  next_prdata[MRC_ACC_S_BIT]        = cur.attr.s;
                  next_prdata[MRC_ACC_TEX_LSB +: 3] = cur.attr.tex;
                  next_prdata[MRC_ACC_AP_LSB +: 3]  = cur.ap;
                  next_prdata[MRC_ACC_NOEXEC_BIT]   = cur.execute_never_flag;
               end
               MRC_OFS_TCM_BASE: next_prdata = tcm_base;
               MRC_OFS_TCM_SIZE: next_prdata[4:0] = tcm_size;
               MRC_OFS_INT_STAT: next_prdata[1:0] = int_stat;
               MRC_OFS_INT_MASK: next_prdata[1:0] = int_mask;
               MRC_OFS_INFO:     next_prdata[7:0] = 8'(NREG);
               MRC_OFS_FLT_ADDR: next_prdata = flt_addr;
               default:          next_pslverr = 1'b1;
            endcase
         end
      end else begin
         next_prdata  = prdata;
         next_pslverr = pslverr;
      end
   end

   // one register stage; reset leaves the checker off and all regions disabled
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NREG; i++) begin
            rgn[i]      <= '0;
            rgn[i].size <= MRC_SIZE_RST;
            rgn[i].ap   <= MRC_AP_RST;
         end
         mpu_en                   <= 1'b0;
         background_region_enable <= 1'b0;
         rgn_sel                  <= 4'h0;
         tcm_base                 <= 32'h00000000;
         tcm_size                 <= 5'h00;
         int_stat                 <= 2'h0;
         int_mask                 <= 2'h0;
         flt_addr                 <= 32'h00000000;
         prdata                   <= 32'h00000000;
         pslverr                  <= 1'b0;
         chk_rsp                  <= '0;
      end else begin
         rgn                      <= next_rgn;
         mpu_en                   <= next_mpu_en;
         background_region_enable <= next_background_region_enable;
         rgn_sel                  <= next_rgn_sel;
         tcm_base                 <= next_tcm_base;
         tcm_size                 <= next_tcm_size;
         int_stat                 <= next_int_stat;
         int_mask                 <= next_int_mask;
         flt_addr                 <= next_flt_addr;
         prdata                   <= next_prdata;
         pslverr                  <= next_pslverr;
         chk_rsp                  <= next_rsp;
      end
   end
endmodule

// ---- hw/mrc_pkg.sv ----
// mrc_pkg: constants, register map and carrier types of the region checker
// assumes a 32-bit APB slave port and a one-cycle check pipeline
package mrc_pkg;
   // register byte offsets
   localparam logic [7:0] MRC_OFS_CTRL     = 8'h00;
   localparam logic [7:0] MRC_OFS_RGN_SEL  = 8'h04;
   localparam logic [7:0] MRC_OFS_RGN_BASE = 8'h08;
   localparam logic [7:0] MRC_OFS_RGN_SIZE = 8'h0C;
   localparam logic [7:0] MRC_OFS_RGN_ACC  = 8'h10;
   localparam logic [7:0] MRC_OFS_TCM_BASE = 8'h14;
   localparam logic [7:0] MRC_OFS_TCM_SIZE = 8'h18;
   localparam logic [7:0] MRC_OFS_INT_STAT = 8'h1C;
   localparam logic [7:0] MRC_OFS_INT_MASK = 8'h20;
   localparam logic [7:0] MRC_OFS_INFO     = 8'h24;
   localparam logic [7:0] MRC_OFS_FLT_ADDR = 8'h28;
   // field positions
   localparam int MRC_CTRL_EN_BIT   = 0;
   localparam int MRC_CTRL_BGEN_BIT = 17;
   localparam int MRC_SIZE_EN_BIT   = 0;
   localparam int MRC_SIZE_LSB      = 1;
   localparam int MRC_SRD_LSB       = 8;
   localparam int MRC_ACC_B_BIT     = 0;
   localparam int MRC_ACC_C_BIT     = 1;
   localparam int MRC_ACC_S_BIT     = 2;
   localparam int MRC_ACC_TEX_LSB   = 3;
   localparam int MRC_ACC_AP_LSB    = 8;
   localparam int MRC_ACC_NOEXEC_BIT = 12;
   localparam int MRC_INT_PERM_BIT  = 0;
   localparam int MRC_INT_BG_BIT    = 1;
   // sizes and defaults
   localparam int         MRC_REGIONS_DEF = 16;
   localparam logic [4:0] MRC_SIZE_MIN    = 5'h07;
   localparam logic [4:0] MRC_SIZE_RST    = 5'h00;
   localparam logic [2:0] MRC_AP_RST      = 3'h0;
   localparam logic [31:0] MRC_BASE_MASK  = 32'hFFFFFF00;
   // normal, non-cacheable, non-shareable
   localparam logic [2:0] MRC_TEX_NORMAL  = 3'h1;

   typedef enum logic [1:0] { MRC_FK_NONE, MRC_FK_PERM, MRC_FK_BACKGROUND } mrc_fault_e;

   typedef struct packed {
      logic        valid;
      logic        fetch;
      logic        write;
      logic        priv;
      logic [31:0] addr;
   } mrc_req_s;

   typedef struct packed {
      logic [2:0] tex;
      logic       c;
      logic       b;
      logic       s;
   } mrc_attr_s;

   typedef struct packed {
      logic        valid;
      logic        fault;
      mrc_fault_e  kind;
      logic        hit;
      logic [3:0]  region;
      logic        rd_ok;
      logic        wr_ok;
      mrc_attr_s   attr;
   } mrc_rsp_s;

   typedef struct packed {
      logic [31:0] base;
      logic [4:0]  size;
      logic        en;
      logic [7:0]  srd;
      logic [2:0]  ap;
      logic        execute_never_flag;
      mrc_attr_s   attr;
   } mrc_region_s;
endpackage

// ---- sim/mrc_top_checker.sv ----
// mrc_top_checker: port assertions of the region checker
// assumes one clock domain; bound onto every mrc_top instance
`timescale 1ns/10ps
module mrc_top_checker import mrc_pkg::*; #(
   parameter int NREG = MRC_REGIONS_DEF
) (
   // clock and reset
   input wire logic              clk_sys,
   input wire logic              reset_n,
   // apb
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [2:0]        pprot,
   input wire logic              pready,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   // check port and interrupt
   input wire mrc_pkg::mrc_req_s chk_req,
   input wire mrc_pkg::mrc_rsp_s chk_rsp,
   input wire logic              irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_rsp_follows_req: assert property (chk_req.valid |=> chk_rsp.valid)
      else $error("check response missing");
   a_no_spurious_rsp: assert property (!chk_req.valid |=> !chk_rsp.valid)
      else $error("response without request");
   a_fault_has_kind: assert property (chk_rsp.fault |-> chk_rsp.kind != MRC_FK_NONE)
      else $error("fault without kind");
   a_bg_no_hit: assert property (
      chk_rsp.fault && chk_rsp.kind == MRC_FK_BACKGROUND |-> !chk_rsp.hit)
      else $error("background fault with a hit");
   a_perm_has_hit: assert property (
      chk_rsp.fault && chk_rsp.kind == MRC_FK_PERM |-> chk_rsp.hit)
      else $error("permission fault without region");
   a_write_needs_ok: assert property (
      chk_req.valid && chk_req.write ##1 chk_rsp.valid && !chk_rsp.fault |-> chk_rsp.wr_ok)
      else $error("write passed without write permission");
   a_read_needs_ok: assert property (
      chk_req.valid && !chk_req.write ##1 chk_rsp.valid && !chk_rsp.fault |-> chk_rsp.rd_ok)
      else $error("read or fetch passed without read permission");
   a_region_range: assert property (chk_rsp.valid && chk_rsp.hit |-> chk_rsp.region < NREG)
      else $error("region index beyond count");
   a_user_reg_err: assert property (psel && !penable && !pprot[0] |=> pslverr)
      else $error("user register access not refused");
   cover property (chk_rsp.fault && chk_rsp.kind == MRC_FK_PERM);
   cover property (chk_rsp.fault && chk_rsp.kind == MRC_FK_BACKGROUND);
   cover property ($rose(irq));
endmodule

bind mrc_top mrc_top_checker #(.NREG(NREG)) u_mrc_chk (.clk_sys(clk_sys), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pprot(pprot), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .chk_req(chk_req), .chk_rsp(chk_rsp), .irq(irq));

// ---- sim/mrc_pipe_model.sv ----
// mrc_pipe_model: fetch and load/store stage issuing one check per command
// assumes the bench raises cmd.valid for one cycle per access
`timescale 1ns/10ps
module mrc_pipe_model import mrc_pkg::*; (
   // clock and reset
   input wire logic              clk_sys,
   input wire logic              reset_n,
   // command from the bench
   input wire mrc_pkg::mrc_req_s cmd,
   // request to the checker
   output mrc_pkg::mrc_req_s     chk_req
);
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         chk_req <= '0;
      end else if (cmd.valid) begin
         chk_req <= cmd;
      end else begin
         // idle address keeps toggling so a stale value never looks valid
         chk_req.valid <= 1'b0;
         chk_req.addr  <= ~chk_req.addr;
      end
   end
endmodule

// ---- sim/mrc_top_test.sv ----
// mrc_top_test: directed scenarios for the region checker
// assumes zero-wait apb and a one-cycle check response
`timescale 1ns/10ps
module mrc_top_test;
   import mrc_pkg::*;
   localparam int NR = 16;
   logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  pprot;
   mrc_req_s    cmd, chk_req;
   mrc_rsp_s    chk_rsp, rsp;
   int          fails, checks, cycles;
   mrc_top #(.NREG(NR)) DUT (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .chk_req(chk_req),
      .chk_rsp(chk_rsp), .irq(irq));
   mrc_pipe_model u_pipe (.clk_sys(clk_sys), .reset_n(reset_n), .cmd(cmd), .chk_req(chk_req));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic tally_and_finish();
      if (fails == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t check result %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] ex(input mrc_fault_e k, input int r);
      return {k != MRC_FK_NONE, k, r >= 0, r >= 0 ? r[3:0] : 4'h0};
   endfunction
   task automatic apb(input logic w, input logic [2:0] p, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      pprot <= p;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, 3'h1, a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, 3'h1, a, 32'h0);
      cmp32(rd, e);
   endtask
   task automatic set_rgn(input logic [3:0] i, input logic [31:0] b, s, c);
      wr(MRC_OFS_RGN_SEL, {28'h0, i});
      wr(MRC_OFS_RGN_BASE, b);
      wr(MRC_OFS_RGN_SIZE, s);
      wr(MRC_OFS_RGN_ACC, c);
   endtask
   task automatic acc(input logic f, w, p, input logic [31:0] a, input logic [7:0] e);
      int n;
      @(posedge clk_sys);
      cmd <= '{1'b1, f, w, p, a};
      @(posedge clk_sys);
      cmd.valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (chk_rsp.valid !== 1'b1 && n < 8);
      rsp = chk_rsp;
      cmp_chk({rsp.fault, rsp.kind, rsp.hit, rsp.hit ? rsp.region : 4'h0}, e);
   endtask
   task automatic t_regs();
      rdchk(MRC_OFS_INFO, NR);
      apb(1'b0, 3'h1, 8'h2C, 32'h0);
      cmp32({31'h0, err}, 32'h1);
      apb(1'b1, 3'h0, MRC_OFS_CTRL, 32'h1);
      cmp32({31'h0, err}, 32'h1);
      rdchk(MRC_OFS_CTRL, 32'h0);
   endtask
   task automatic t_prio();
      set_rgn(4'h1, 32'h0, 32'h1B, 32'h307);
      set_rgn(4'h2, 32'h3000, 32'h17, 32'h200);
      rdchk(MRC_OFS_RGN_SIZE, 32'h17);
      wr(MRC_OFS_CTRL, 32'h1);
      acc(1'b0, 1'b1, 1'b0, 32'h3010, ex(MRC_FK_PERM, 2));
      acc(1'b0, 1'b0, 1'b0, 32'h3010, ex(MRC_FK_NONE, 2));
      acc(1'b0, 1'b1, 1'b0, 32'h2000, ex(MRC_FK_NONE, 1));
      cmp32({26'h0, rsp.attr}, 32'h07);
      wr(MRC_OFS_RGN_SEL, 32'h2);
      wr(MRC_OFS_RGN_SIZE, 32'h117);
      acc(1'b0, 1'b1, 1'b0, 32'h3010, ex(MRC_FK_NONE, 1));
      acc(1'b0, 1'b1, 1'b0, 32'h3200, ex(MRC_FK_PERM, 2));
   endtask
   task automatic t_bg_exec();
      acc(1'b0, 1'b0, 1'b1, 32'h10000, ex(MRC_FK_BACKGROUND, -1));
      wr(MRC_OFS_CTRL, 32'h20001);
      acc(1'b0, 1'b0, 1'b1, 32'h10000, ex(MRC_FK_NONE, -1));
      acc(1'b0, 1'b0, 1'b0, 32'h10000, ex(MRC_FK_BACKGROUND, -1));
      set_rgn(4'h3, 32'h8000, 32'h0F, 32'h1300);
      acc(1'b1, 1'b0, 1'b1, 32'h8000, ex(MRC_FK_PERM, 3));
      acc(1'b0, 1'b0, 1'b1, 32'h8000, ex(MRC_FK_NONE, 3));
      set_rgn(4'h4, 32'h9000, 32'h0F, 32'h100);
      acc(1'b0, 1'b0, 1'b0, 32'h9000, ex(MRC_FK_PERM, 4));
      acc(1'b1, 1'b0, 1'b0, 32'h9000, ex(MRC_FK_PERM, 4));
      acc(1'b1, 1'b0, 1'b1, 32'h9000, ex(MRC_FK_NONE, 4));
      wr(MRC_OFS_RGN_ACC, 32'h500);
      acc(1'b0, 1'b1, 1'b1, 32'h9000, ex(MRC_FK_PERM, 4));
   endtask
   task automatic t_tcm_irq();
      wr(MRC_OFS_TCM_BASE, 32'h0);
      wr(MRC_OFS_TCM_SIZE, 32'hD);
      acc(1'b0, 1'b1, 1'b0, 32'h2000, ex(MRC_FK_NONE, 1));
      cmp32({26'h0, rsp.attr}, 32'h08);
      wr(MRC_OFS_INT_STAT, 32'h3);
      wr(MRC_OFS_INT_MASK, 32'h1);
      acc(1'b0, 1'b1, 1'b0, 32'h3200, ex(MRC_FK_PERM, 2));
      cmp32({31'h0, irq}, 32'h1);
      acc(1'b0, 1'b0, 1'b0, 32'h10000, ex(MRC_FK_BACKGROUND, -1));
      wr(MRC_OFS_INT_STAT, 32'h1);
      #1;
      cmp32({31'h0, irq}, 32'h0);
      rdchk(MRC_OFS_INT_STAT, 32'h2);
      rdchk(MRC_OFS_FLT_ADDR, 32'h00010000);
   endtask
   initial begin
      {reset_n, psel, penable, pwrite, paddr, pwdata, pprot} = '0;
      cmd = '0;
      fails = 0;
      checks = 0;
      cycles = 0;
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_regs();
      t_prio();
      t_bg_exec();
      t_tcm_irq();
      tally_and_finish();
   end
endmodule
